// ---- verilog/plcs_consts.svh ----
// Offsets, field positions, reset values and counts of the link control and status register bank.
`ifndef PLCS_CONSTS_SVH
`define PLCS_CONSTS_SVH
`define PLCS_OFF_LINK 8'hF0
`define PLCS_OFF_SLOTCLK 8'hFC
`define PLCS_ADDR_W 8
`define PLCS_BIT_RCB 3
`define PLCS_BIT_LDIS 4
`define PLCS_BIT_RETRAIN 5
`define PLCS_BIT_CCLK 6
`define PLCS_BIT_XSYNC 7
`define PLCS_LSB_SPEED 16
`define PLCS_LSB_WIDTH 20
`define PLCS_BIT_TERR 26
`define PLCS_BIT_TRAIN 27
`define PLCS_BIT_SCLK 28
`define PLCS_BIT_DLACT 29
`define PLCS_SPEED_2G5 4'h1
`define PLCS_WIDTH_X1 6'h01
`define PLCS_ASPM_RST 2'h0
`define PLCS_ASPM_OFF 2'h0
`define PLCS_ASPM_L0S 2'h1
`define PLCS_ASPM_L1 2'h2
`define PLCS_ASPM_BOTH 2'h3
`define PLCS_FTS_EXT 13'h1000
`define PLCS_TS1_EXT 13'h0400
`define PLCS_FTS_NORM 13'h0080
`define PLCS_TS1_NORM 13'h0010
`define PLCS_RESP_OKAY 2'h0
`define PLCS_RESP_SLVERR 2'h2
`endif

// ---- verilog/plcs_pkg.sv ----
// Types shared by the link control and status register bank.
package plcs_pkg;
   typedef logic [1:0] plcs_resp_t;
   typedef logic [1:0] plcs_aspm_t;
   typedef logic [12:0] plcs_os_count_t;
endpackage : plcs_pkg

// ---- verilog/plcs_regs.sv ----
// Link control and link status register bank with an AXI4-Lite slave port.
//
// Contract
// - ASPM field 00 off, 01 L0s, 10 L1, 11 both.
// - Receiver may enter L0s even when disabled.
// - Bit 3 reads as zero always.
// - Upstream port link disable fixed at zero.
// - Downstream link disable holds link down while set.
// - Upstream port retrain bit fixed at zero.
// - Downstream retrain write of one starts training.
// - Retrain bit always reads back as zero.
// - Bit 6 declares common reference clock, resets zero.
// - Extended sync sends 4096 FTS leaving L0s.
// - Extended sync sends 1024 TS1 leaving L1.
// - Speed field 19:16 always reads one.
// - Width field 25:20 reports single lane.
// - Training error bit set on training error.
// - Training error cleared on successful L0 training.
// - Training bit high while training in progress.
// - Bit 28 reports slot clock source.
// - Slot clock defaults from strap, overridable.
// - Bit 29 reads one in DL active state.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "plcs_consts.svh"

module plcs_regs #(
   parameter bit IS_UPSTREAM = 1'b0,
   parameter logic [5:0] NEG_WIDTH = `PLCS_WIDTH_X1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output plcs_pkg::plcs_resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output plcs_pkg::plcs_resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic train_error_evt,
   input wire logic train_start_evt,
   input wire logic train_done_l0,
   input wire logic dl_active,
   input wire logic slot_clk_strap,
   input wire logic preload_valid,
   input wire logic preload_slot_clk,
   output logic aspm_l0s_en,
   output logic aspm_l1_en,
   output logic rx_l0s_allowed,
   output logic link_disable,
   output logic retrain_req,
   output logic common_clk,
   output logic ext_sync,
   output plcs_pkg::plcs_os_count_t fts_count,
   output plcs_pkg::plcs_os_count_t ts1_count,
   output logic slot_clk_cfg
);

   // Register state.
   plcs_pkg::plcs_aspm_t aspm_r;
   logic ldis_r;
   logic cclk_r;
   logic xsync_r;
   logic retrain_r;
   logic terr_r;
   logic train_r;
   logic sclk_r;
   logic strap_taken_r;
   logic strap_s1_r;
   logic strap_s2_r;

   // Bus state.
   logic aw_have_r;
   logic w_have_r;
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   plcs_pkg::plcs_resp_t bresp_r;
   logic rvalid_r;
   plcs_pkg::plcs_resp_t rresp_r;
   logic [31:0] rdata_r;

   logic wr_fire;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_link;
   logic wr_slot;
   logic rd_fire;
   logic [31:0] link_word;

   // The address and data channels are accepted independently and held until both are present.
   assign s_axi_awready = ce && !aw_have_r && !bvalid_r;
   assign s_axi_wready = ce && !w_have_r && !bvalid_r;
   assign s_axi_arready = ce && !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // A write is carried out in the cycle in which both halves are known, taken now or held.
   assign wr_addr = aw_have_r ? awaddr_r : s_axi_awaddr;
   assign wr_data = w_have_r ? wdata_r : s_axi_wdata;
   assign wr_strb = w_have_r ? wstrb_r : s_axi_wstrb;
   assign wr_fire = ce && !bvalid_r && (aw_have_r || s_axi_awvalid) && (w_have_r || s_axi_wvalid);
   assign wr_link = wr_fire && ({wr_addr[`PLCS_ADDR_W-1:2], 2'b00} == `PLCS_OFF_LINK);
   assign wr_slot = wr_fire && ({wr_addr[`PLCS_ADDR_W-1:2], 2'b00} == `PLCS_OFF_SLOTCLK);
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // Address channel holding stage.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         awaddr_r <= 32'h0;
      end
      else if (ce)
      begin
         if (wr_fire)
            aw_have_r <= 1'b0;
         else if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
      end
   end

   // Data channel holding stage.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_r <= 1'b0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end
      else if (ce)
      begin
         if (wr_fire)
            w_have_r <= 1'b0;
         else if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error so software notices.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `PLCS_RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_link || wr_slot) ? `PLCS_RESP_OKAY : `PLCS_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // Control half: only byte lane 0 holds writable bits; lane 1 and the status lanes are ignored.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aspm_r <= `PLCS_ASPM_RST;
         ldis_r <= 1'b0;
         cclk_r <= 1'b0;
         xsync_r <= 1'b0;
      end
      else if (ce && wr_link && wr_strb[0])
      begin
         aspm_r <= wr_data[1:0];
         ldis_r <= IS_UPSTREAM ? 1'b0 : wr_data[`PLCS_BIT_LDIS];
         cclk_r <= wr_data[`PLCS_BIT_CCLK];
         xsync_r <= wr_data[`PLCS_BIT_XSYNC];
      end
   end

   // Retrain is a one-cycle registered request; the read view forces bit 5 to zero, so it cannot read back as one.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         retrain_r <= 1'b0;
      else if (ce)
         retrain_r <= !IS_UPSTREAM && wr_link && wr_strb[0] && wr_data[`PLCS_BIT_RETRAIN];
   end

   // Training flags; a new event in the cycle of completion wins, so none is lost.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         terr_r <= 1'b0;
         train_r <= 1'b0;
      end
      else if (ce)
      begin
         if (train_error_evt)
            terr_r <= 1'b1;
         else if (train_done_l0)
            terr_r <= 1'b0;
         if (train_start_evt || retrain_r)
            train_r <= 1'b1;
         else if (train_done_l0)
            train_r <= 1'b0;
      end
   end

   // Strap pin passes two flops; the first is read by nothing else.
   // They run through reset, so the second already holds the pin level when the default is caught.
   always_ff @(posedge aclk)
   begin
      if (ce)
      begin
         strap_s1_r <= slot_clk_strap;
         strap_s2_r <= strap_s1_r;
      end
   end

   // Slot clock default is caught from the strap after reset, then preload or software may override.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_r <= 1'b0;
         strap_taken_r <= 1'b0;
      end
      else if (ce)
      begin
         if (!strap_taken_r)
         begin
            strap_taken_r <= 1'b1;
            sclk_r <= strap_s2_r;
         end
         else if (preload_valid)
            sclk_r <= preload_slot_clk;
         else if (wr_slot && wr_strb[0])
            sclk_r <= wr_data[0];
      end
   end

   // Read view of the shared word: control in the low half, status in the high half.
   always_comb
   begin
      link_word = 32'h0;
      link_word[1:0] = aspm_r;
      link_word[`PLCS_BIT_RCB] = 1'b0;
      link_word[`PLCS_BIT_LDIS] = ldis_r;
      link_word[`PLCS_BIT_RETRAIN] = 1'b0;
      link_word[`PLCS_BIT_CCLK] = cclk_r;
      link_word[`PLCS_BIT_XSYNC] = xsync_r;
      link_word[`PLCS_LSB_SPEED +: 4] = `PLCS_SPEED_2G5;
      link_word[`PLCS_LSB_WIDTH +: 6] = NEG_WIDTH;
      link_word[`PLCS_BIT_TERR] = terr_r;
      link_word[`PLCS_BIT_TRAIN] = train_r;
      link_word[`PLCS_BIT_SCLK] = sclk_r;
      link_word[`PLCS_BIT_DLACT] = dl_active;
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= `PLCS_RESP_OKAY;
         rdata_r <= 32'h0;
      end
      else if (ce)
      begin
         if (rd_fire)
         begin
            rvalid_r <= 1'b1;
            if ({s_axi_araddr[`PLCS_ADDR_W-1:2], 2'b00} == `PLCS_OFF_LINK)
            begin
               rdata_r <= link_word;
               rresp_r <= `PLCS_RESP_OKAY;
            end
            else if ({s_axi_araddr[`PLCS_ADDR_W-1:2], 2'b00} == `PLCS_OFF_SLOTCLK)
            begin
               rdata_r <= {31'h0, sclk_r};
               rresp_r <= `PLCS_RESP_OKAY;
            end
            else
            begin
               rdata_r <= 32'h0;
               rresp_r <= `PLCS_RESP_SLVERR;
            end
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   // Controls toward the physical layer.
   assign aspm_l0s_en = aspm_r[0];
   assign aspm_l1_en = aspm_r[1];
   assign rx_l0s_allowed = 1'b1;
   assign link_disable = ldis_r;
   assign retrain_req = retrain_r;
   assign common_clk = cclk_r;
   assign ext_sync = xsync_r;
   assign fts_count = xsync_r ? `PLCS_FTS_EXT : `PLCS_FTS_NORM;
   assign ts1_count = xsync_r ? `PLCS_TS1_EXT : `PLCS_TS1_NORM;
   assign slot_clk_cfg = sclk_r;

   // Checks on the bank's own behaviour.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_link_write_lane0;
      ce && wr_link && wr_strb[0];
   endsequence

   sequence s_read_link;
      ce && rd_fire && ({s_axi_araddr[`PLCS_ADDR_W-1:2], 2'b00} == `PLCS_OFF_LINK);
   endsequence

   a_aspm_write_lands: assert property (s_link_write_lane0 |=> (aspm_r == $past(wr_data[1:0])))
      else $error("ASPM field did not take the written value.");

   a_aspm_enables: assert property (aspm_l0s_en == (aspm_r == `PLCS_ASPM_L0S || aspm_r == `PLCS_ASPM_BOTH)
      && aspm_l1_en == (aspm_r == `PLCS_ASPM_L1 || aspm_r == `PLCS_ASPM_BOTH))
      else $error("ASPM enables disagree with the field.");

   a_rx_l0s_open: assert property (aspm_r == `PLCS_ASPM_OFF |-> rx_l0s_allowed)
      else $error("Receiver L0s blocked while ASPM is off.");

   a_read_fixed_bits: assert property (s_read_link |=> s_axi_rvalid && !s_axi_rdata[`PLCS_BIT_RCB]
      && !s_axi_rdata[`PLCS_BIT_RETRAIN] && s_axi_rdata[31:30] == 2'h0 && s_axi_rdata[15:8] == 8'h00
      && s_axi_rdata[19:16] == `PLCS_SPEED_2G5)
      else $error("Fixed bits of the link word read wrong.");

   a_upstream_fixed: assert property (IS_UPSTREAM |-> !link_disable && !retrain_req)
      else $error("Upstream port drove link disable or retrain.");

   a_disable_holds: assert property (s_link_write_lane0 ##0 wr_data[`PLCS_BIT_LDIS] && !IS_UPSTREAM
      |=> link_disable)
      else $error("Link disable did not follow a write of one.");

   a_retrain_pulse: assert property (s_link_write_lane0 ##0 wr_data[`PLCS_BIT_RETRAIN] && !IS_UPSTREAM
      |=> retrain_req ##1 (train_r || !$past(ce)))
      else $error("Retrain write did not start training.");

   a_ext_counts: assert property (ext_sync |-> fts_count == 13'h1000 && ts1_count == 13'h0400)
      else $error("Extended sync counts are wrong.");

   a_terr_set_wins: assert property (ce && train_error_evt |=> terr_r)
      else $error("Training error event was lost.");

   a_terr_clear: assert property (ce && train_done_l0 && !train_error_evt |=> !terr_r)
      else $error("Training error not cleared on L0.");

   a_train_clear: assert property (ce && train_done_l0 && !train_start_evt && !retrain_r |=> !train_r)
      else $error("Training flag not cleared on completion.");

   a_strap_capture: assert property (ce && !strap_taken_r |=> sclk_r == $past(strap_s2_r))
      else $error("Slot clock did not take the strap level.");

   a_status_view: assert property (s_read_link |=> s_axi_rdata[`PLCS_BIT_DLACT] == $past(dl_active)
      && s_axi_rdata[`PLCS_BIT_SCLK] == $past(sclk_r) && s_axi_rdata[25:20] == NEG_WIDTH)
      else $error("Status half does not show the block state.");

endmodule : plcs_regs

// ---- bench/tb_pcie_link_control_status_regs.sv ----
// Self-checking testbench for the link control and status register bank.
`timescale 1ns/100ps
`include "plcs_consts.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_pcie_link_control_status_regs;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_rdata;
   plcs_pkg::plcs_resp_t s_axi_bresp, s_axi_rresp;
   logic train_error_evt = 1'b0, train_start_evt = 1'b0, train_done_l0 = 1'b0, dl_active = 1'b0;
   logic slot_clk_strap = 1'b1, preload_valid = 1'b0, preload_slot_clk = 1'b0;
   logic aspm_l0s_en, aspm_l1_en, rx_l0s_allowed, link_disable, retrain_req, common_clk, ext_sync, slot_clk_cfg;
   plcs_pkg::plcs_os_count_t fts_count, ts1_count;
   int failures = 0;
   int compares = 0;
   int rt_cnt = 0;
   int seed = 32'h5C19C456;
   logic [7:0] ctl_m = 8'h00;
   logic terr_m = 1'b0, train_m = 1'b0, sclk_m = 1'b1;

   // Downstream port instance; every port matches a bench signal of the same name.
   plcs_regs u_plcs_regs (.*);

   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;

   // Counts retrain pulses mid-cycle, so a pulse longer than one cycle is counted once for each cycle it lasts.
   always @(negedge aclk)
   begin
      if (retrain_req === 1'b1)
         rt_cnt++;
   end

   // Expected link word built from the bench's own model of the bank.
   function automatic logic [31:0] exp_word();
      return {2'h0, dl_active, sclk_m, train_m, terr_m, `PLCS_WIDTH_X1, `PLCS_SPEED_2G5, 8'h00, ctl_m & 8'hD3};
   endfunction : exp_word

   // Ends the run with the counts and the verdict.
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // Write with both channels offered together; readies are sampled mid-cycle where they are settled.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output plcs_pkg::plcs_resp_t r);
      bit aw_done, w_done, a_hs, w_hs, b_hs;
      aw_done = 0;
      w_done = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(negedge aclk);
         a_hs = s_axi_awvalid && (s_axi_awready === 1'b1);
         w_hs = s_axi_wvalid && (s_axi_wready === 1'b1);
         @(posedge aclk);
         if (a_hs)
         begin
            s_axi_awvalid <= 1'b0;
            aw_done = 1;
         end
         if (w_hs)
         begin
            s_axi_wvalid <= 1'b0;
            w_done = 1;
         end
      end
      do
      begin
         @(negedge aclk);
         b_hs = (s_axi_bvalid === 1'b1);
         r = s_axi_bresp;
         @(posedge aclk);
      end while (!b_hs);
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // Read of one word; rready is held until rvalid is seen.
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output plcs_pkg::plcs_resp_t r);
      bit hs;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         hs = s_axi_arvalid && (s_axi_arready === 1'b1);
         @(posedge aclk);
      end while (!hs);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         hs = (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!hs);
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Reads the link word and compares it and every control output except retrain_req with the model.
   task automatic check_all(input string what);
      logic [31:0] d;
      plcs_pkg::plcs_resp_t r;
      axi_read({24'h0, `PLCS_OFF_LINK}, d, r);
      `CHK(what, exp_word(), d)
      `CHK("rresp", `PLCS_RESP_OKAY, r)
      `CHK("l0s_en", ctl_m[0], aspm_l0s_en)
      `CHK("l1_en", ctl_m[1], aspm_l1_en)
      `CHK("rx_l0s", 1'b1, rx_l0s_allowed)
      `CHK("link_disable", ctl_m[4], link_disable)
      `CHK("common_clk", ctl_m[6], common_clk)
      `CHK("ext_sync", ctl_m[7], ext_sync)
      `CHK("fts_count", ctl_m[7] ? `PLCS_FTS_EXT : `PLCS_FTS_NORM, fts_count)
      `CHK("ts1_count", ctl_m[7] ? `PLCS_TS1_EXT : `PLCS_TS1_NORM, ts1_count)
      `CHK("slot_clk_cfg", sclk_m, slot_clk_cfg)
   endtask : check_all

   // Pulses one status event input for a single cycle: 0 error, 1 done, 2 start, 3 preload.
   task automatic pulse(input int k);
      @(posedge aclk);
      case (k)
         0: train_error_evt <= 1'b1;
         1: train_done_l0 <= 1'b1;
         2: train_start_evt <= 1'b1;
         default: preload_valid <= 1'b1;
      endcase
      @(posedge aclk);
      {train_error_evt, train_done_l0, train_start_evt, preload_valid} <= 4'h0;
      @(posedge aclk);
   endtask : pulse

   // Main sequence: reset, then one block of traffic per behaviour.
   initial
   begin
      logic [31:0] d;
      plcs_pkg::plcs_resp_t r;
      int n;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      check_all("reset word");
      $display("Test reset values done");
      // The first four writes walk all power management codes with every read-only bit set.
      for (int i = 0; i < 24; i++)
      begin
         d = (i < 4) ? (32'hFFFFFFDC | i) : ($random(seed) & ~32'h20);
         ctl_m = d[7:0];
         dl_active <= d[29];
         axi_write({24'h0, `PLCS_OFF_LINK}, d, r);
         `CHK("bresp", `PLCS_RESP_OKAY, r)
         check_all("link word");
      end
      $display("Test control writes done");
      n = rt_cnt;
      ctl_m = 8'h00;
      axi_write({24'h0, `PLCS_OFF_LINK}, 32'h0000_0020, r);
      train_m = 1'b1;
      check_all("after retrain");
      `CHK("retrain pulses", n + 1, rt_cnt)
      pulse(0);
      terr_m = 1'b1;
      check_all("training error");
      pulse(1);
      terr_m = 1'b0;
      train_m = 1'b0;
      check_all("trained to L0");
      pulse(2);
      train_m = 1'b1;
      check_all("training start");
      // An error event while the clock enable is low must leave every flag frozen.
      ce <= 1'b0;
      pulse(0);
      `CHK("arready frozen", 1'b0, s_axi_arready)
      ce <= 1'b1;
      check_all("clock enable low");
      $display("Test training status done");
      preload_slot_clk <= 1'b0;
      pulse(3);
      sclk_m = 1'b0;
      check_all("slot clock preload");
      axi_write({24'h0, `PLCS_OFF_SLOTCLK}, 32'h1, r);
      `CHK("slot bresp", `PLCS_RESP_OKAY, r)
      sclk_m = 1'b1;
      check_all("slot clock override");
      $display("Test slot clock done");
      axi_read(32'h0000_0008, d, r);
      `CHK("unmapped rresp", `PLCS_RESP_SLVERR, r)
      `CHK("unmapped rdata", 32'h0, d)
      axi_write(32'h0000_0008, 32'hFFFFFFFF, r);
      `CHK("unmapped bresp", `PLCS_RESP_SLVERR, r)
      check_all("after unmapped");
      $display("Test unmapped access done");
      end_of_test();
   end

   // Watchdog: the tests need well under a thousand cycles.
   initial
   begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_of_test();
   end
endmodule : tb_pcie_link_control_status_regs
